// *** design/crf_pkg.sv ***
// Package for the CAN receiver flag and status block
package crf_pkg;
    localparam logic [7:0] CRF_ADDR_WIDTH = 8'h08;
    localparam logic [7:0] CRF_OFF_FLAGS = 8'h04;
    localparam logic [7:0] CRF_OFF_ENABLES = 8'h05;
    localparam logic [7:0] CRF_OFF_TIMING = 8'h10;
    localparam logic [7:0] CRF_OFF_CONTROL = 8'h11;
    localparam logic [7:0] CRF_OFF_COUNTERS_RX = 8'h12;
    localparam logic [7:0] CRF_OFF_COUNTERS_TX = 8'h13;
    localparam logic [7:0] CRF_OFF_BIT_TIME = 8'h14;
    localparam int CRF_BIT_WAKEUP = 7;
    localparam int CRF_BIT_STATUS = 6;
    localparam int CRF_BIT_OVERRUN = 1;
    localparam int CRF_BIT_RXFULL = 0;
    localparam logic [7:0] CRF_FLAGS_RESET = 8'h00;
    localparam logic [7:0] CRF_ENABLES_RESET = 8'h00;
    localparam logic [7:0] CRF_TIMING_RESET = 8'h00;
    localparam logic [8:0] CRF_WARN_LIMIT = 9'h060;
    localparam logic [8:0] CRF_PASSIVE_LIMIT = 9'h07F;
    localparam logic [8:0] CRF_BUSOFF_LIMIT = 9'h0FF;
    typedef enum logic [1:0] {
        CRF_ST_OK,
        CRF_ST_WARN,
        CRF_ST_ERR,
        CRF_ST_BUSOFF
    } crf_state_t;
endpackage : crf_pkg

// *** design/crf_state_enc.sv ***
// Error counter to bus state encoder
`timescale 1ns/1ns
module crf_state_enc
    import crf_pkg::*;
(
    input wire logic [8:0] rx_count_i,
    input wire logic [8:0] tx_count_i,
    output crf_state_t rx_state_o,
    output crf_state_t tx_state_o
);
    always_comb begin
        if (tx_count_i > CRF_BUSOFF_LIMIT) begin
            rx_state_o = CRF_ST_BUSOFF;
            tx_state_o = CRF_ST_BUSOFF;
        end else begin
            if (rx_count_i <= CRF_WARN_LIMIT) begin
                rx_state_o = CRF_ST_OK;
            end else if (rx_count_i <= CRF_PASSIVE_LIMIT) begin
                rx_state_o = CRF_ST_WARN;
            end else begin
                rx_state_o = CRF_ST_ERR;
            end
            if (tx_count_i <= CRF_WARN_LIMIT) begin
                tx_state_o = CRF_ST_OK;
            end else if (tx_count_i <= CRF_PASSIVE_LIMIT) begin
                tx_state_o = CRF_ST_WARN;
            end else begin
                tx_state_o = CRF_ST_ERR;
            end
        end
    end
endmodule : crf_state_enc

// *** design/crf_bit_time.sv ***
// Bit time length in module clocks from prescaler and segments
`timescale 1ns/1ns
module crf_bit_time (
    input wire logic [5:0] prescaler_i,
    input wire logic [3:0] seg1_i,
    input wire logic [2:0] seg2_i,
    output logic [10:0] clocks_o
);
    logic [6:0] p_val;
    logic [4:0] quanta;
    always_comb begin
        p_val = {1'b0, prescaler_i} + 7'h01;
        quanta = 5'h01 + ({1'b0, seg1_i} + 5'h01) + ({2'b00, seg2_i} + 5'h01);
        clocks_o = 11'(p_val) * 11'(quanta);
    end
endmodule : crf_bit_time

// *** design/crf_top.sv ***
// Receiver flag and status register block
// Operation
// - Bit time is (prescaler+1) times (seg1+seg2+3)
// - Flags clear by writing one after cause
// - Writing zero leaves flag untouched
// - Init mode holds flags reset, ignores flag writes
// - Flag writes accepted again after init exit
// - State fields read-only, writes discarded
// - State fields track bus during init
// - Enable per flag, interrupt while set
// - Wakeup flag on sleep activity if enabled
// - Status change flag on bus state change
// - State fields frozen while status flag set
// - Receiver state encoding from error counts
// - Transmitter state encoding from error counts
// - Overrun flag raises error interrupt
// - Receive full set on good frame
// - Full flag blocks foreground shift
// - Receive interrupt while full and enabled
`timescale 1ns/1ns
module crf_top
    import crf_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic init_request_i,
    input wire logic init_acknowledge_i,
    input wire logic sleep_mode_i,
    input wire logic bus_activity_i,
    input wire logic overrun_event_i,
    input wire logic rx_condition_i,
    input wire logic fifo_entry_valid_i,
    input wire logic [8:0] rx_err_count_i,
    input wire logic [8:0] tx_err_count_i,
    output logic fifo_shift_o,
    output logic wakeup_irq_o,
    output logic error_irq_o,
    output logic receive_irq_o,
    output logic [10:0] bit_time_clocks_o
);
    import crf_pkg::*;

    logic [7:0] flags_q, flags_d;
    logic [7:0] enables_q, enables_d;
    logic [12:0] timing_q, timing_d;
    logic wakeup_enable_q, wakeup_enable_d;
    logic [1:0] rx_state_q, rx_state_d;
    logic [1:0] tx_state_q, tx_state_d;
    logic [7:0] rdata_q, rdata_d;
    logic overrun_hold_q, overrun_hold_d;
    crf_state_t rx_now, tx_now;
    logic init_mode, run_mode, flag_wr, status_chg, shift_ok;
    logic [7:0] set_ev, cause, clr;

    crf_state_enc u_enc (
        .rx_count_i(rx_err_count_i),
        .tx_count_i(tx_err_count_i),
        .rx_state_o(rx_now),
        .tx_state_o(tx_now)
    );

    crf_bit_time u_bt (
        .prescaler_i(timing_q[5:0]),
        .seg1_i(timing_q[9:6]),
        .seg2_i(timing_q[12:10]),
        .clocks_o(bit_time_clocks_o)
    );

    always_comb begin
        init_mode = init_request_i & init_acknowledge_i;
        run_mode = ~init_request_i & ~init_acknowledge_i;
        flag_wr = wr_i & (addr_i == CRF_OFF_FLAGS) & run_mode;
        status_chg = ({rx_now, tx_now} != {rx_state_q, tx_state_q});
        shift_ok = fifo_entry_valid_i & ~flags_q[CRF_BIT_RXFULL];
        fifo_shift_o = shift_ok;
        set_ev = 8'h00;
        set_ev[CRF_BIT_WAKEUP] = sleep_mode_i & bus_activity_i & wakeup_enable_q;
        set_ev[CRF_BIT_STATUS] = status_chg & ~flags_q[CRF_BIT_STATUS];
        set_ev[CRF_BIT_OVERRUN] = overrun_event_i;
        set_ev[CRF_BIT_RXFULL] = shift_ok;
        cause = 8'h00;
        cause[CRF_BIT_WAKEUP] = sleep_mode_i & bus_activity_i;
        cause[CRF_BIT_OVERRUN] = overrun_event_i | overrun_hold_q;
        cause[CRF_BIT_RXFULL] = 1'b0;
        clr = 8'h00;
        if (flag_wr) begin
            clr = wdata_i & ~cause & 8'hC3;
        end
        flags_d = flags_q;
        flags_d[5:2] = 4'h0;
        flags_d = (flags_d & ~clr) | set_ev;
        if (init_mode) begin
            flags_d = CRF_FLAGS_RESET;
        end
        overrun_hold_d = overrun_event_i;
        rx_state_d = rx_state_q;
        tx_state_d = tx_state_q;
        if (!flags_q[CRF_BIT_STATUS]) begin
            rx_state_d = rx_now;
            tx_state_d = tx_now;
        end
        enables_d = enables_q;
        if (init_mode) begin
            enables_d = CRF_ENABLES_RESET;
        end else if (wr_i && addr_i == CRF_OFF_ENABLES && run_mode) begin
            enables_d = wdata_i;
        end
        timing_d = timing_q;
        wakeup_enable_d = wakeup_enable_q;
        if (wr_i && addr_i == CRF_OFF_TIMING && init_mode) begin
            timing_d[7:0] = wdata_i;
        end
        if (wr_i && addr_i == CRF_OFF_CONTROL) begin
            if (init_mode) begin
                timing_d[12:8] = wdata_i[4:0];
            end
            wakeup_enable_d = wdata_i[7];
        end
        rdata_d = 8'h00;
        if (rd_i) begin
            unique case (addr_i)
                CRF_OFF_FLAGS: rdata_d = {flags_q[7:6], rx_state_q, tx_state_q, flags_q[1:0]};
                CRF_OFF_ENABLES: rdata_d = enables_q;
                CRF_OFF_TIMING: rdata_d = timing_q[7:0];
                CRF_OFF_CONTROL: rdata_d = {wakeup_enable_q, 2'b00, timing_q[12:8]};
                CRF_OFF_COUNTERS_RX: rdata_d = rx_err_count_i[7:0];
                CRF_OFF_COUNTERS_TX: rdata_d = tx_err_count_i[7:0];
                CRF_OFF_BIT_TIME: rdata_d = bit_time_clocks_o[7:0];
                default: rdata_d = 8'h00;
            endcase
        end
        wakeup_irq_o = flags_q[CRF_BIT_WAKEUP] & enables_q[CRF_BIT_WAKEUP];
        error_irq_o = (flags_q[CRF_BIT_STATUS] & enables_q[CRF_BIT_STATUS])
                    | (flags_q[CRF_BIT_OVERRUN] & enables_q[CRF_BIT_OVERRUN]);
        receive_irq_o = flags_q[CRF_BIT_RXFULL] & enables_q[CRF_BIT_RXFULL];
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            flags_q <= CRF_FLAGS_RESET;
            enables_q <= CRF_ENABLES_RESET;
            timing_q <= 13'h0000;
            wakeup_enable_q <= 1'b0;
            rx_state_q <= 2'b00;
            tx_state_q <= 2'b00;
            rdata_q <= 8'h00;
            overrun_hold_q <= 1'b0;
        end else begin
            flags_q <= flags_d;
            enables_q <= enables_d;
            timing_q <= timing_d;
            wakeup_enable_q <= wakeup_enable_d;
            rx_state_q <= rx_state_d;
            tx_state_q <= tx_state_d;
            rdata_q <= rdata_d;
            overrun_hold_q <= overrun_hold_d;
        end
    end

    assign rdata_o = rdata_q;
endmodule : crf_top

// *** tb/crf_top_monitor.sv ***
// Port checker for the receiver flag block
`timescale 1ns/1ns
module crf_top_monitor (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic init_request_i,
    input wire logic init_acknowledge_i,
    input wire logic overrun_event_i,
    input wire logic fifo_entry_valid_i,
    input wire logic fifo_shift_o,
    input wire logic error_irq_o,
    input wire logic receive_irq_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    wire ini = init_request_i && init_acknowledge_i;
    wire flag_wr = wr_i && addr_i == 8'h04;
    read_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("rdata not zero outside read answer");
    init_irq_a: assert property (ini |=> !error_irq_o && !receive_irq_o)
        else $error("irq seen in init mode");
    init_read_a: assert property (ini && $past(ini) && rd_i && addr_i == 8'h04 |=>
        rdata_o[7:6] == 2'h0 && rdata_o[1:0] == 2'h0) else $error("flag set in init");
    shift_cause_a: assert property (fifo_shift_o |-> fifo_entry_valid_i)
        else $error("shift without frame");
    shift_once_a: assert property (fifo_shift_o && !ini |=> !fifo_shift_o)
        else $error("shift while buffer full");
    full_block_a: assert property (receive_irq_o |-> !fifo_shift_o)
        else $error("shift during receive irq");
    zero_wr_a: assert property (flag_wr && wdata_i == 8'h00 && !ini && !fifo_shift_o
        |=> $stable(receive_irq_o)) else $error("zero write moved flag");
    ovr_hold_a: assert property (error_irq_o && overrun_event_i && !ini
        && !(wr_i && addr_i == 8'h05) |=> error_irq_o) else $error("overrun cleared early");
endmodule : crf_top_monitor
bind crf_top crf_top_monitor MON (.*);

// *** tb/crf_can_node.sv ***
// Far side node model delivering received frames
`timescale 1ns/1ns
module crf_can_node (
    input wire logic clk_i,
    input wire logic frame_i,
    input wire logic shift_i,
    output logic valid_o
);
    int pend = 0;
    always @(posedge clk_i) pend <= pend + int'(frame_i) - int'(shift_i && valid_o);
    assign valid_o = pend > 0;
endmodule : crf_can_node

// *** tb/tb_top.sv ***
// Testbench for the receiver flag block
`timescale 1ns/1ns
module tb_top;
    logic clk = 0, rst = 1, wr = 0, rd = 0, ini = 0, slp = 0, act = 0, ovr = 0, frm = 0;
    logic [7:0] a = 0, d = 0, q;
    logic [8:0] rxc = 0, txc = 0;
    logic vld, sh, wi, ei, ri;
    logic [10:0] bt;
    logic [25:0] tab [4] = '{26'h0006144, 26'h0008048, 26'h001007C, 26'h0000040};
    int bad_count = 0, checked = 0;
    always #4 clk = ~clk;
    crf_can_node N (.clk_i(clk), .frame_i(frm), .shift_i(sh), .valid_o(vld));
    crf_top DUT (.ref_clk_i(clk), .sys_rst_i(rst), .addr_i(a), .wdata_i(d), .wr_i(wr),
        .rd_i(rd), .rdata_o(q), .init_request_i(ini), .init_acknowledge_i(ini),
        .sleep_mode_i(slp), .bus_activity_i(act), .overrun_event_i(ovr),
        .rx_condition_i(1'b0), .fifo_entry_valid_i(vld), .rx_err_count_i(rxc),
        .tx_err_count_i(txc), .fifo_shift_o(sh), .wakeup_irq_o(wi), .error_irq_o(ei),
        .receive_irq_o(ri), .bit_time_clocks_o(bt));
    task automatic ck(input string n, input logic [10:0] e, input logic [10:0] g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s exp %h got %h", n, e, g);
        end
    endtask : ck
    task automatic n(input int k);
        repeat (k) @(posedge clk);
    endtask : n
    task automatic w(input logic [7:0] ad, input logic [7:0] dv);
        @(posedge clk) begin a <= ad; d <= dv; wr <= 1; end
        @(posedge clk) wr <= 0;
    endtask : w
    task automatic r(input logic [7:0] ad, input logic [7:0] e);
        @(posedge clk) begin a <= ad; rd <= 1; end
        @(posedge clk) rd <= 0;
        #1 ck("rdata", {3'h0, e}, {3'h0, q});
    endtask : r
    task automatic f;
        @(posedge clk) frm <= 1;
        @(posedge clk) frm <= 0;
    endtask : f
    task automatic tally_and_finish;
        $display("Checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : tally_and_finish
    initial begin
        n(5000);
        bad_count++;
        tally_and_finish();
    end
    initial begin
        n(16);
        rst <= 0;
        r(8'h04, 8'h00);
        r(8'h07, 8'h00);
        w(8'h05, 8'hC3);
        w(8'h11, 8'h80);
        f(); n(2); r(8'h04, 8'h01);
        ck("receive_irq", 1, ri);
        f(); n(2); ck("fifo_shift", 0, sh);
        w(8'h04, 8'h00); r(8'h04, 8'h01);
        w(8'h04, 8'h01); n(1); r(8'h04, 8'h01);
        w(8'h04, 8'h01); r(8'h04, 8'h00);
        @(posedge clk) ovr <= 1;
        w(8'h04, 8'h02); ck("error_irq", 1, ei);
        r(8'h04, 8'h02);
        @(posedge clk) ovr <= 0;
        n(2); w(8'h04, 8'h02); r(8'h04, 8'h00);
        @(posedge clk) begin slp <= 1; act <= 1; end
        n(2); ck("wakeup_irq", 1, wi);
        w(8'h04, 8'h80); r(8'h04, 8'h80);
        @(posedge clk) act <= 0;
        w(8'h04, 8'h80); r(8'h04, 8'h00);
        @(posedge clk) begin slp <= 0; rxc <= 9'h061; end
        n(2); r(8'h04, 8'h50);
        ck("error_irq", 1, ei);
        @(posedge clk) rxc <= 9'h080;
        n(2); r(8'h04, 8'h50);
        w(8'h04, 8'h40); n(2); r(8'h04, 8'h60);
        foreach (tab[i]) begin
            @(posedge clk) {rxc, txc} <= tab[i][25:8];
            n(2); w(8'h04, 8'h40); n(2); r(8'h04, tab[i][7:0]);
        end
        @(posedge clk) ini <= 1;
        n(2); w(8'h04, 8'hFF);
        @(posedge clk) rxc <= 9'h061;
        n(2); r(8'h04, 8'h10);
        w(8'h10, 8'h03); w(8'h11, 8'h89); n(1);
        ck("bit_time", 11'h024, bt);
        w(8'h10, 8'hFF); w(8'h11, 8'h9F); n(1);
        ck("bit_time", 11'h640, bt);
        @(posedge clk) ini <= 0;
        n(1); w(8'h05, 8'hC3);
        @(posedge clk) ovr <= 1;
        @(posedge clk) ovr <= 0;
        n(2); w(8'h04, 8'h02); r(8'h04, 8'h10);
        w(8'h04, 8'h3C); r(8'h04, 8'h10);
        tally_and_finish();
    end
endmodule : tb_top
